// ---- src/cssl_slot_zero.sv ----
/*
 * Slot-zero controller of one chassis: target-select shift register with
 * module select decode, scan-timing control register, and scan-list FIFO
 * with the sample counter that walks it.
 * Assumes all serial pins and the sample clock are asynchronous to clk_sys
 * and slower than a quarter of its rate; chassis_number and single_chassis are
 * static jumper levels.
 */
`timescale 1ns/1ns

module cssl_slot_zero (
   // Clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   // Serial link pins
   input  wire logic                        zero_select_n,
   input  wire logic                        serial_shift_clock,
   input  wire logic                        serial_data_in,
   // Jumpers
   input  wire logic [cssl_pkg::CHS_W-1:0]  chassis_number,
   input  wire logic                        single_chassis,
   // Sample clock from the acquisition board
   input  wire logic                        sample_clock,
   // Module selects, active low, one per slot
   output logic      [cssl_pkg::SLOTS-1:0]  module_select_n,
   // Scan-control lines, active low, one per slot
   output logic      [cssl_pkg::SLOTS-1:0]  scan_control_line_n,
   // Scan status
   output logic      [cssl_pkg::SLOT_W-1:0] scan_slot,
   output logic                             scan_done
);

   typedef struct packed {
      logic [cssl_pkg::TS_W-1:0]    target_select;
      logic [cssl_pkg::STC_W-1:0]   stc_shift;
      logic [cssl_pkg::ENTRY_W-1:0] entry_shift;
      logic [4:0]                   bit_count;
      logic [cssl_pkg::STC_W-1:0]   scan_timing_control;
      logic [8:0]                   entries;
      logic [cssl_pkg::PTR_W-1:0]   read_ptr;
      logic [cssl_pkg::CNT_W-1:0]   sample_left;
      logic                         done;
      logic [cssl_pkg::SLOTS-1:0]   sel_n;
      logic [cssl_pkg::SLOTS-1:0]   scan_n;
      logic [cssl_pkg::SLOT_W-1:0]  slot;
   } cssl_state_t;

   cssl_state_t st_q;
   cssl_state_t st_d;

   // Scan list storage
   logic [cssl_pkg::ENT_KEEP_W-1:0] list_mem [cssl_pkg::LIST_DEPTH];
   logic                            mem_we;
   logic [cssl_pkg::PTR_W-1:0]      mem_waddr;
   logic [cssl_pkg::ENT_KEEP_W-1:0] mem_wdata;

   // Synchronised pins
   logic [3:0] pin_lvl;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;

   cssl_pin_sync #(
      .W (4)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin_in  ({sample_clock, serial_data_in, serial_shift_clock, zero_select_n}),
      .level   (pin_lvl),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   logic zs_lvl;
   logic zs_rise;
   logic zs_fall;
   logic sclk_rise;
   logic sdi;
   logic smp_rise;
   assign zs_lvl    = pin_lvl[0];
   assign zs_rise   = pin_rise[0];
   assign zs_fall   = pin_fall[0];
   assign sclk_rise = pin_rise[1];
   assign sdi       = pin_lvl[2];
   assign smp_rise  = pin_rise[3];

   // Selection decode
   logic                        chs_match;
   logic [cssl_pkg::SLOT_W-1:0] sel_slot;
   logic                        selected;
   assign chs_match = single_chassis
                      | (st_q.target_select[cssl_pkg::CHS_HI:cssl_pkg::CHS_LO] == chassis_number);
   assign sel_slot  = st_q.target_select[cssl_pkg::SLOT_HI:cssl_pkg::SLOT_LO];
   assign selected  = zs_lvl & chs_match;

   // Current entry and the one after it
   logic [cssl_pkg::ENT_KEEP_W-1:0] cur_entry;
   logic [cssl_pkg::ENT_KEEP_W-1:0] first_entry;
   logic [cssl_pkg::PTR_W-1:0]      next_ptr;
   logic                            at_end;
   assign cur_entry   = list_mem[st_q.read_ptr];
   assign first_entry = list_mem[{cssl_pkg::PTR_W{1'b0}}];
   assign next_ptr    = st_q.read_ptr + 8'h01;
   assign at_end      = ({1'b0, next_ptr} == st_q.entries) || (st_q.read_ptr == 8'hFF);

   logic scanning;
   assign scanning = st_q.scan_timing_control[cssl_pkg::STC_CLK_EN] && !st_q.done
                     && (st_q.entries != 9'h000);

   always_comb begin
      logic [cssl_pkg::STC_W-1:0] stc;
      stc       = st_q.stc_shift;
      st_d      = st_q;
      mem_we    = 1'b0;
      mem_waddr = st_q.entries[cssl_pkg::PTR_W-1:0];
      mem_wdata = st_q.entry_shift[cssl_pkg::ENT_KEEP_W-1:0];

      // Scan stepping on each sample
      if (scanning && smp_rise) begin
         if (st_q.sample_left != 7'h00) begin
            st_d.sample_left = st_q.sample_left - 7'h01;
         end else if (at_end) begin
            if (st_q.scan_timing_control[cssl_pkg::STC_SINGLE]) begin
               st_d.done = 1'b1;
            end else begin
               st_d.read_ptr    = '0;
               st_d.sample_left = first_entry[cssl_pkg::ENT_CNT_HI:cssl_pkg::ENT_CNT_LO];
            end
         end else begin
            st_d.read_ptr    = next_ptr;
            st_d.sample_left = list_mem[next_ptr][cssl_pkg::ENT_CNT_HI:cssl_pkg::ENT_CNT_LO];
         end
      end

      // Serial shifting on rising shift clock edges
      if (sclk_rise) begin
         if (!zs_lvl) begin
            st_d.target_select = {st_q.target_select[cssl_pkg::TS_W-2:0], sdi};
         end else if (selected && sel_slot == cssl_pkg::SLOT_TIMING) begin
            st_d.stc_shift = {st_q.stc_shift[cssl_pkg::STC_W-2:0], sdi};
            if (st_q.bit_count != cssl_pkg::STC_BITS) begin
               st_d.bit_count = st_q.bit_count + 5'h01;
            end
         end else if (selected && sel_slot == cssl_pkg::SLOT_LIST) begin
            st_d.entry_shift = {st_q.entry_shift[cssl_pkg::ENTRY_W-2:0], sdi};
            if (st_q.bit_count != cssl_pkg::ENTRY_BITS) begin
               st_d.bit_count = st_q.bit_count + 5'h01;
            end
         end
      end

      // New selection starts a fresh word
      if (zs_rise) begin
         st_d.bit_count = '0;
      end

      // Deselect commits the shifted word
      if (zs_fall && chs_match) begin
         if (sel_slot == cssl_pkg::SLOT_TIMING && st_q.bit_count == cssl_pkg::STC_BITS) begin
            st_d.scan_timing_control = stc;
            if (!stc[cssl_pkg::STC_REWIND_N]) begin
               st_d.read_ptr = '0;
               st_d.done     = 1'b0;
            end
            if (!stc[cssl_pkg::STC_LOAD_N]) begin
               st_d.sample_left = list_mem[st_d.read_ptr][cssl_pkg::ENT_CNT_HI:cssl_pkg::ENT_CNT_LO];
            end
            if (!stc[cssl_pkg::STC_RESET_N]) begin
               st_d.entries     = '0;
               st_d.read_ptr    = '0;
               st_d.sample_left = '0;
               st_d.done        = 1'b0;
            end
         end else if (sel_slot == cssl_pkg::SLOT_LIST && st_q.bit_count == cssl_pkg::ENTRY_BITS) begin
            if (st_q.entries != cssl_pkg::LIST_FULL) begin
               mem_we       = 1'b1;
               st_d.entries = st_q.entries + 9'h001;
               if (st_q.entries == 9'h000) begin
                  st_d.sample_left = st_q.entry_shift[cssl_pkg::ENT_CNT_HI:cssl_pkg::ENT_CNT_LO];
               end
            end
         end
      end

      // Module selects: none while zero select is low
      st_d.sel_n = '1;
      if (selected && !zs_fall) begin
         st_d.sel_n[sel_slot] = 1'b0;
      end

      // Scan-control lines
      st_d.slot   = cur_entry[cssl_pkg::ENT_SLOT_HI:cssl_pkg::ENT_SLOT_LO] + 4'h1;
      st_d.scan_n = '1;
      if (st_q.scan_timing_control[cssl_pkg::STC_SCAN_EN] && scanning) begin
         st_d.scan_n[st_d.slot] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q                     <= '0;
         st_q.scan_timing_control <= cssl_pkg::STC_RESET;
         st_q.sel_n               <= '1;
         st_q.scan_n              <= '1;
      end else begin
         st_q <= st_d;
      end
   end

   // Scan list memory: contents survive erase, which clears the count, read pointer, sample counter and done flag
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         list_mem[mem_waddr] <= mem_wdata;
      end
   end

   assign module_select_n     = st_q.sel_n;
   assign scan_control_line_n = st_q.scan_n;
   assign scan_slot           = st_q.slot;
   assign scan_done           = st_q.done;

endmodule : cssl_slot_zero

// ---- src/cssl_pkg.sv ----
/*
 * Constants for the chassis slot-select and scan-list block: register widths,
 * field positions, special slot numbers and scan-list depth.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package cssl_pkg;

   // Register widths
   localparam int TS_W    = 16;
   localparam int STC_W   = 8;
   localparam int ENTRY_W = 16;
   localparam logic [4:0] TS_BITS    = 5'h10;
   localparam logic [4:0] STC_BITS   = 5'h08;
   localparam logic [4:0] ENTRY_BITS = 5'h10;

   // Target-select fields
   localparam int CHS_HI  = 8;
   localparam int CHS_LO  = 4;
   localparam int SLOT_HI = 3;
   localparam int SLOT_LO = 0;
   localparam int CHS_W   = 5;
   localparam int SLOT_W  = 4;
   localparam int SLOTS   = 16;

   // Slots that reach this block's own registers
   localparam logic [3:0] SLOT_TIMING = 4'hD;
   localparam logic [3:0] SLOT_LIST   = 4'hE;

   // Scan-timing control bits
   localparam int STC_REWIND_N  = 6;
   localparam int STC_SINGLE    = 4;
   localparam int STC_RESET_N   = 3;
   localparam int STC_LOAD_N    = 2;
   localparam int STC_SCAN_EN   = 1;
   localparam int STC_CLK_EN    = 0;
   localparam logic [7:0] STC_RESET = 8'h00;

   // Scan-list entry fields
   localparam int ENT_SLOT_HI = 10;
   localparam int ENT_SLOT_LO = 7;
   localparam int ENT_CNT_HI  = 6;
   localparam int ENT_CNT_LO  = 0;
   localparam int ENT_KEEP_W  = 11;
   localparam int CNT_W       = 7;

   // Scan list depth
   localparam int LIST_DEPTH = 256;
   localparam int PTR_W      = 8;
   localparam logic [8:0] LIST_FULL = 9'h100;

   // Synchroniser depth ahead of the edge stage
   localparam int SYNC_STAGES = 2;

endpackage : cssl_pkg

// ---- src/cssl_pin_sync.sv ----
/*
 * Two-flop synchroniser with a third stage for edge detection, one per bit.
 * Assumes the inputs are asynchronous pins; outputs are on clk_sys.
 */
`timescale 1ns/1ns
module cssl_pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // Pin side
   input  wire logic [W-1:0] pin_in,
   // Synchronous side
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '1;
         sync_q <= '1;
         prev_q <= '1;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   genvar i;
   for (i = 0; i < W; i++) begin : g_edge
      assign level[i] = sync_q[i];
      assign rise[i]  = sync_q[i] & ~prev_q[i];
      assign fall[i]  = ~sync_q[i] & prev_q[i];
   end

endmodule : cssl_pin_sync

// ---- dv/cssl_slot_zero_monitor.sv ----
/* Checker for the slot-zero pins: select decode, scan lines, scan status.
   Assumes it is bound to cssl_slot_zero on clk_sys with rst_n. */
`timescale 1ns/1ns
module cssl_slot_zero_monitor (
   // Clock and reset
   input wire logic                        clk_sys,
   input wire logic                        rst_n,
   // Watched pins
   input wire logic                        zero_select_n,
   input wire logic [cssl_pkg::SLOTS-1:0]  module_select_n,
   input wire logic [cssl_pkg::SLOTS-1:0]  scan_control_line_n,
   input wire logic [cssl_pkg::SLOT_W-1:0] scan_slot,
   input wire logic                        scan_done
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_one_select: assert property ($onehot0(~module_select_n))
      else $error("More than one module select low");
   a_low_clears: assert property ($fell(zero_select_n) |-> ##[1:6] (&module_select_n))
      else $error("Selects not cleared after zero select fell");
   a_low_holds: assert property (!zero_select_n [*6] |-> (&module_select_n))
      else $error("Select low while zero select low");
   a_high_stable: assert property (zero_select_n [*8] |-> $stable(module_select_n))
      else $error("Selects changed while zero select high");
   a_select_cause: assert property (!(&module_select_n) && $past(&module_select_n)
      |-> zero_select_n && $past(zero_select_n, 3))
      else $error("Select appeared without zero select high");
   a_scan_line_slot: assert property (!(&scan_control_line_n)
      |-> $onehot0(~scan_control_line_n) && !scan_control_line_n[scan_slot])
      else $error("Scan line not that of the scan slot");
   a_done_freeze: assert property (scan_done && $past(scan_done) |-> scan_slot == $past(scan_slot))
      else $error("Scan slot moved after single pass ended");
   a_done_commit: assert property ($fell(scan_done) |-> !zero_select_n)
      else $error("Done cleared outside a register commit");
endmodule : cssl_slot_zero_monitor

bind cssl_slot_zero cssl_slot_zero_monitor i_cssl_slot_zero_monitor (
   .clk_sys, .rst_n, .zero_select_n, .module_select_n, .scan_control_line_n, .scan_slot, .scan_done);

// ---- dv/cssl_daq_model.sv ----
/* Acquisition board model: drives zero select, serial clock, data and sample clock.
   Assumes clk_sys at 4 ns; 20 cycles give the 80 ns serial clock. */
`timescale 1ns/1ns
module cssl_daq_model (
   // Clock
   input  wire logic clk_sys,
   // Serial link and sample pins
   output logic      zero_select_n,
   output logic      serial_shift_clock,
   output logic      serial_data_in,
   output logic      sample_clock
);
   initial begin
      zero_select_n      = 1'b1;
      serial_shift_clock = 1'b1;
      serial_data_in     = 1'b0;
      sample_clock       = 1'b0;
   end
   task automatic put_bit(input logic b);
      serial_data_in     <= b;
      serial_shift_clock <= 1'b0;
      repeat (10) @(posedge clk_sys);
      serial_shift_clock <= 1'b1;
      repeat (10) @(posedge clk_sys);
   endtask : put_bit
   task automatic put8(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) put_bit(v[i]);
      serial_data_in <= ~v[0];
   endtask : put8
   task automatic put16(input logic [15:0] v);
      for (int i = 15; i >= 0; i--) put_bit(v[i]);
      serial_data_in <= ~v[0];
   endtask : put16
   // Low commits the previous word, then shifts a new target and selects it
   task automatic select(input logic [15:0] t);
      zero_select_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      put16(t);
      zero_select_n <= 1'b1;
      repeat (10) @(posedge clk_sys);
   endtask : select
   task automatic sample();
      sample_clock <= 1'b1;
      repeat (10) @(posedge clk_sys);
      sample_clock <= 1'b0;
      repeat (10) @(posedge clk_sys);
   endtask : sample
endmodule : cssl_daq_model

// ---- dv/test_chassis_slot_select_scan_list.sv ----
/* Testbench: select decode, timing register and scan list through the serial pins.
   Assumes chassis jumper 3 outside the jumper scenarios, which move jumpers only while zero select is low;
   the timing register is programmed at target 16'h003D and the list at 16'h003E. */
`timescale 1ns/1ns
module test_chassis_slot_select_scan_list;
   logic        clk_sys;
   logic        rst_n;
   logic        zero_select_n;
   logic        serial_shift_clock;
   logic        serial_data_in;
   logic        sample_clock;
   logic [4:0]  chassis_number;
   logic        single_chassis;
   logic [15:0] module_select_n;
   logic [15:0] scan_control_line_n;
   logic [3:0]  scan_slot;
   logic        scan_done;
   int          bad_count;
   int          tests_run;
   logic [7:0]  timing_copy;

   cssl_daq_model i_cssl_daq_model (.clk_sys(clk_sys), .zero_select_n(zero_select_n),
      .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in), .sample_clock(sample_clock));
   cssl_slot_zero i_cssl_slot_zero (.clk_sys(clk_sys), .rst_n(rst_n), .zero_select_n(zero_select_n),
      .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in),
      .chassis_number(chassis_number), .single_chassis(single_chassis), .sample_clock(sample_clock),
      .module_select_n(module_select_n), .scan_control_line_n(scan_control_line_n),
      .scan_slot(scan_slot), .scan_done(scan_done));

   task automatic test_done();
      if (bad_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_timing(input logic [7:0] v);
      timing_copy = v;
      i_cssl_daq_model.select(16'h003D);
      i_cssl_daq_model.put8(v);
      i_cssl_daq_model.select(16'h0000);
   endtask : wr_timing
   task automatic wr_list(input logic [15:0] v);
      i_cssl_daq_model.select(16'h003E);
      i_cssl_daq_model.put16(v);
      i_cssl_daq_model.select(16'h0000);
   endtask : wr_list
   // Jumpers move only while zero select is low, so no select changes while it is high
   task automatic set_jumpers(input logic [15:0] t, input logic [4:0] chs, input logic one);
      fork
         i_cssl_daq_model.select(t);
         begin
            repeat (4) @(posedge clk_sys);
            chassis_number <= chs;
            single_chassis <= one;
         end
      join
   endtask : set_jumpers

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      #100000;
      bad_count++;
      test_done();
   end
   initial begin
      rst_n          = 1'b0;
      chassis_number = 5'h03;
      single_chassis = 1'b0;
      timing_copy    = 8'h00;
      bad_count      = 0;
      tests_run      = 0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk(module_select_n, 16'hFFFF);
      i_cssl_daq_model.select(16'hFE35);
      chk(module_select_n, 16'hFFDF);
      i_cssl_daq_model.select(16'h0045);
      chk(module_select_n, 16'hFFFF);
      set_jumpers(16'h0045, 5'h03, 1'b1);
      chk(module_select_n, 16'hFFDF);
      set_jumpers(16'h01C5, 5'h1C, 1'b0);
      chk(module_select_n, 16'hFFDF);
      set_jumpers(16'h0000, 5'h03, 1'b0);
      chk(module_select_n, 16'hFFFF);
      wr_list(16'h0380);
      chk({12'h000, scan_slot}, 16'h0008);
      wr_timing(8'h57);
      wr_list(16'hF901);
      chk({12'h000, scan_slot}, 16'h0003);
      wr_list(16'h0280);
      chk({12'h000, scan_slot}, 16'h0003);
      wr_timing(8'h5F);
      chk(scan_control_line_n, 16'hFFF7);
      i_cssl_daq_model.sample();
      chk({12'h000, scan_slot}, 16'h0003);
      i_cssl_daq_model.sample();
      chk({12'h000, scan_slot}, 16'h0006);
      i_cssl_daq_model.sample();
      chk({15'h0000, scan_done}, 16'h0001);
      wr_timing(8'h1F);
      chk({11'h000, scan_done, scan_slot}, 16'h0003);
      wr_timing(8'h5D);
      chk(scan_control_line_n, timing_copy[cssl_pkg::STC_SCAN_EN] ? 16'hFFF7 : 16'hFFFF);
      wr_timing(8'h4B);
      repeat (2) i_cssl_daq_model.sample();
      chk({11'h000, scan_done, scan_slot}, 16'h0006);
      i_cssl_daq_model.sample();
      chk({11'h000, scan_done, scan_slot}, 16'h0003);
      // Reset in mid-run while the scan lines are driven
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk(scan_control_line_n, 16'hFFFF);
      chk(module_select_n, 16'hFFFF);
      chk({15'h0000, scan_done}, 16'h0000);
      test_done();
   end
endmodule : test_chassis_slot_select_scan_list
